// file: pkg/ett_regs.vh
// register map, field positions, reset values and codes of the 8-bit timer
`ifndef ETT_REGS_VH
`define ETT_REGS_VH
// register indices; byte address is four times the index
`define ETT_IDX_CNT 8'hCA
`define ETT_IDX_CTL 8'hCB
`define ETT_IDX_CCTL0 8'hCC
`define ETT_IDX_CC0 8'hCD
`define ETT_IDX_CCTL1 8'hCE
`define ETT_IDX_CC1 8'hCF
`define ETT_IDX_FLAG 8'hD0
`define ETT_IDX_IEN 8'hD1
// timer_control fields
`define ETT_CTL_DIV_HI 7
`define ETT_CTL_DIV_LO 5
`define ETT_CTL_START 4
`define ETT_CTL_OVERFLOW_IRQ_MASK 3
`define ETT_CTL_CLR 2
`define ETT_CTL_MODE_HI 1
`define ETT_CTL_MODE_LO 0
`define ETT_CTL_RESET 8'h08
// channel_control fields
`define ETT_CCTL_IM 6
`define ETT_CCTL_CMP_HI 5
`define ETT_CCTL_CMP_LO 3
`define ETT_CCTL_EN 2
`define ETT_CCTL_RESET 8'h40
`define ETT_CCTL_MASK 8'h7C
// timer_flag_register bits
`define ETT_FLAG_OVF 0
`define ETT_FLAG_CH0 1
`define ETT_FLAG_CH1 2
// modes
`define ETT_MODE_FREE 2'h0
`define ETT_MODE_DOWN 2'h1
`define ETT_MODE_MOD 2'h2
`define ETT_MODE_UPDN 2'h3
// compare actions
`define ETT_CMP_SET 3'h0
`define ETT_CMP_CLR 3'h1
`define ETT_CMP_TOG 3'h2
`define ETT_CMP_SETUP 3'h3
`define ETT_CMP_CLRUP 3'h4
`define ETT_CMP_SETMAX 3'h5
`define ETT_CMP_CLRZERO 3'h6
// counter limits and bus answers
`define ETT_CNT_ZERO 8'h00
`define ETT_CNT_MAX 8'hFF
`define ETT_RESP_OKAY 2'h0
`define ETT_RESP_DECERR 2'h3
`endif

// file: hdl/ett_timer.v
// 8-bit timer with two compare channels, flags, interrupt gating and AXI4-Lite registers
// Functional notes
// - modulo mode starts at zero and increments once per prescaled tick
// - modulo mode reloads zero on the tick after the counter equals channel-0 compare
// - modulo mode sets the overflow flag when the channel-0 compare value is reached
// - overflow pends to the cpu only with its mask; request also needs timer enable
// - down mode loads channel-0 compare on start, counts to zero and holds there
// - down mode sets the overflow flag on reaching zero
// - up/down mode counts up to channel-0 compare, then down to zero, repeating
// - up/down mode sets the overflow flag when the counter returns to zero
// - enabled channel drives its pin and compares counter with its compare value while running
// - on a match the pin is set, cleared or toggled per its compare action
// - pin transitions come from flip-flops so they are glitch-free
// - channel-0 compare writes are buffered and applied when the counter is zero
// - channel-1 compare writes take effect at once
// - match sets channel flag; pending needs channel mask; request also needs enable
// - up/down mode sets channel-0 flag at turn-around on zero; channel 1 still on match
// - flags are set by events regardless of mask bits
// - setting a mask while its flag is set raises a new request
// - all timer events share one interrupt vector, numbered by a parameter
// - each channel compare event pulses its own dma trigger
// - counter register reads the live 8-bit count and resets to zero
// - mode field: 00 free, 01 down, 10 modulo, 11 up/down
// - compare action codes 000 to 110 as set, clear, toggle and pwm variants
// - start bit 1 runs the counter, 0 freezes it at its present value
// - prescaler divides the tick by 2 to the power code, effective immediately
`timescale 1ns/10ps
`include "ett_regs.vh"

module ett_timer #(
    parameter IRQ_VECTOR = 11,
    parameter ADDR_W = 12
) (
    input wire aclk,
    input wire aresetn,
    input wire timer_tick,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg ch0_pin_out,
    output wire ch0_pin_oe,
    output reg ch1_pin_out,
    output wire ch1_pin_oe,
    output wire cpu_timer_pending,
    output wire timer_irq_req,
    output wire [3:0] timer_irq_vector,
    output reg timer_a_ch0_dma_trigger,
    output reg timer_a_ch1_dma_trigger
);

    // registers
    reg [7:0] counter_value_reg;
    reg [7:0] timer_control_reg;
    reg [7:0] channel_control0_reg;
    reg [7:0] channel_control1_reg;
    reg [7:0] compare_value_ch0_reg;
    reg [7:0] cc0_active_reg;
    reg [7:0] compare_value_ch1_reg;
    reg [2:0] timer_flag_reg;
    reg timer_irq_enable_reg;
    reg count_down_reg;
    reg [6:0] prescale_reg;

    // bus state
    reg [ADDR_W-1:0] awaddr_reg;
    reg aw_held_reg;
    reg [31:0] wdata_reg;
    reg wstrb0_reg;
    reg w_held_reg;

    wire [2:0] div_code = timer_control_reg[`ETT_CTL_DIV_HI:`ETT_CTL_DIV_LO];
    wire [1:0] mode = timer_control_reg[`ETT_CTL_MODE_HI:`ETT_CTL_MODE_LO];
    wire start = timer_control_reg[`ETT_CTL_START];
    wire [2:0] cmp0 = channel_control0_reg[`ETT_CCTL_CMP_HI:`ETT_CCTL_CMP_LO];
    wire [2:0] cmp1 = channel_control1_reg[`ETT_CCTL_CMP_HI:`ETT_CCTL_CMP_LO];
    wire en0 = channel_control0_reg[`ETT_CCTL_EN];
    wire en1 = channel_control1_reg[`ETT_CCTL_EN];

    // prescaled active edge: low div bits of the free prescaler all zero; a new
    // divider is used from the next tick, with no wait for a period to end
    wire [6:0] div_mask = 7'h7F >> (3'd7 - div_code);
    wire active_edge = timer_tick && ((prescale_reg & div_mask) == 7'h00);
    wire step = active_edge && start;

    // bus decode
    wire do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
    wire [ADDR_W-3:0] widx = awaddr_reg[ADDR_W-1:2];
    wire [ADDR_W-3:0] ridx = s_axi_araddr[ADDR_W-1:2];
    wire wr_en = do_write && wstrb0_reg;
    wire wr_ctl = wr_en && (widx == `ETT_IDX_CTL);
    wire wr_cc0 = wr_en && (widx == `ETT_IDX_CC0);
    wire wr_flag = wr_en && (widx == `ETT_IDX_FLAG);
    wire [7:0] wbyte = wdata_reg[7:0];
    wire start_rise = wr_ctl && wbyte[`ETT_CTL_START] && !start;

    // next counter value and the terminal events it produces
    reg [7:0] cnt_next;
    reg dir_next;
    reg ovf_evt;
    reg turn_zero;
    always @*
    begin
        cnt_next = counter_value_reg;
        dir_next = count_down_reg;
        ovf_evt = 1'b0;
        turn_zero = 1'b0;
        if (step)
        begin
            case (mode)
                `ETT_MODE_FREE:
                begin
                    cnt_next = counter_value_reg + 8'h01;
                    ovf_evt = (cnt_next == `ETT_CNT_MAX);
                end
                `ETT_MODE_MOD:
                begin
                    if (counter_value_reg >= cc0_active_reg)
                        cnt_next = `ETT_CNT_ZERO;
                    else
                        cnt_next = counter_value_reg + 8'h01;
                    ovf_evt = (cnt_next == cc0_active_reg);
                end
                `ETT_MODE_DOWN:
                begin
                    if (counter_value_reg != `ETT_CNT_ZERO)
                        cnt_next = counter_value_reg - 8'h01;
                    ovf_evt = (counter_value_reg != `ETT_CNT_ZERO) && (cnt_next == `ETT_CNT_ZERO);
                end
                default:
                begin
                    if (!count_down_reg)
                    begin
                        if (counter_value_reg >= cc0_active_reg)
                        begin
                            dir_next = 1'b1;
                            if (counter_value_reg != `ETT_CNT_ZERO)
                                cnt_next = counter_value_reg - 8'h01;
                        end
                        else
                            cnt_next = counter_value_reg + 8'h01;
                    end
                    else if (counter_value_reg == `ETT_CNT_ZERO)
                    begin
                        dir_next = 1'b0;
                        cnt_next = 8'h01;
                    end
                    else
                        cnt_next = counter_value_reg - 8'h01;
                    turn_zero = count_down_reg && (cnt_next == `ETT_CNT_ZERO);
                    ovf_evt = turn_zero;
                end
            endcase
        end
    end

    // compare events happen when the counter steps onto the compare value
    wire at_zero = step && (cnt_next == `ETT_CNT_ZERO);
    wire at_max = step && (cnt_next == `ETT_CNT_MAX);
    wire match0 = step && en0 && (cnt_next == cc0_active_reg);
    wire match1 = step && en1 && (cnt_next == compare_value_ch1_reg);
    wire updn = (mode == `ETT_MODE_UPDN);
    wire ch0_evt = updn ? turn_zero : match0;

    // pin action; the result is registered so a pin changes once, cleanly
    function pin_next;
        input pin;
        input [2:0] cmp;
        input match;
        input down;
        input zero;
        input maxv;
        begin
            pin_next = pin;
            case (cmp)
                `ETT_CMP_SET: if (match) pin_next = 1'b1;
                `ETT_CMP_CLR: if (match) pin_next = 1'b0;
                `ETT_CMP_TOG: if (match) pin_next = !pin;
                `ETT_CMP_SETUP:
                begin
                    if (match) pin_next = !down;
                    else if (zero) pin_next = 1'b0;
                end
                `ETT_CMP_CLRUP:
                begin
                    if (match) pin_next = down;
                    else if (zero) pin_next = 1'b1;
                end
                `ETT_CMP_SETMAX:
                begin
                    if (match) pin_next = 1'b1;
                    else if (maxv) pin_next = 1'b0;
                end
                `ETT_CMP_CLRZERO:
                begin
                    if (match) pin_next = 1'b0;
                    else if (zero) pin_next = 1'b1;
                end
                default: pin_next = pin;
            endcase
        end
    endfunction

    // direction in force once the step lands, so compare-down is seen at the top
    wire down_now = updn && dir_next;
    wire run0 = step && en0;
    wire run1 = step && en1;

    // counter, direction and prescaler
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            counter_value_reg <= `ETT_CNT_ZERO;
            count_down_reg <= 1'b0;
            prescale_reg <= 7'h00;
        end
        else
        begin
            if (timer_tick)
                prescale_reg <= prescale_reg + 7'h01;
            if (wr_ctl && wbyte[`ETT_CTL_CLR])
            begin
                counter_value_reg <= `ETT_CNT_ZERO;
                count_down_reg <= 1'b0;
            end
            else if (start_rise && (wbyte[`ETT_CTL_MODE_HI:`ETT_CTL_MODE_LO] == `ETT_MODE_DOWN))
                counter_value_reg <= cc0_active_reg;
            else
            begin
                counter_value_reg <= cnt_next;
                count_down_reg <= updn ? dir_next : 1'b0;
            end
        end
    end

    // channel pins, dma pulses and channel-0 compare buffer
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ch0_pin_out <= 1'b0;
            ch1_pin_out <= 1'b0;
            timer_a_ch0_dma_trigger <= 1'b0;
            timer_a_ch1_dma_trigger <= 1'b0;
            cc0_active_reg <= `ETT_CNT_ZERO;
        end
        else
        begin
            if (run0)
                ch0_pin_out <= pin_next(ch0_pin_out, cmp0, match0, down_now, at_zero, at_max);
            if (run1)
                ch1_pin_out <= pin_next(ch1_pin_out, cmp1, match1, down_now, at_zero, at_max);
            timer_a_ch0_dma_trigger <= match0;
            timer_a_ch1_dma_trigger <= match1;
            if (counter_value_reg == `ETT_CNT_ZERO)
                cc0_active_reg <= compare_value_ch0_reg;
        end
    end

    // pins are driven only while the channel compare output is enabled
    assign ch0_pin_oe = en0;
    assign ch1_pin_oe = en1;

    // software registers and sticky flags; a write of 0 clears a flag, but an
    // event in the same cycle wins so it is never lost
    wire [2:0] flag_evt = {match1, ch0_evt, ovf_evt};
    wire [2:0] flag_keep = wr_flag ? (timer_flag_reg & wbyte[2:0]) : timer_flag_reg;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            timer_control_reg <= `ETT_CTL_RESET;
            channel_control0_reg <= `ETT_CCTL_RESET;
            channel_control1_reg <= `ETT_CCTL_RESET;
            compare_value_ch0_reg <= `ETT_CNT_ZERO;
            compare_value_ch1_reg <= `ETT_CNT_ZERO;
            timer_flag_reg <= 3'h0;
            timer_irq_enable_reg <= 1'b0;
        end
        else
        begin
            timer_flag_reg <= flag_keep | flag_evt;
            if (wr_ctl)
                timer_control_reg <= wbyte & ~(8'h01 << `ETT_CTL_CLR); // clear bit reads 0
            if (wr_en && (widx == `ETT_IDX_CCTL0))
                channel_control0_reg <= wbyte & `ETT_CCTL_MASK;
            if (wr_en && (widx == `ETT_IDX_CCTL1))
                channel_control1_reg <= wbyte & `ETT_CCTL_MASK;
            if (wr_cc0)
                compare_value_ch0_reg <= wbyte;
            if (wr_en && (widx == `ETT_IDX_CC1))
                compare_value_ch1_reg <= wbyte;
            if (wr_en && (widx == `ETT_IDX_IEN))
                timer_irq_enable_reg <= wbyte[0];
        end
    end

    // interrupt gating is level based, so unmasking a set flag requests anew
    assign cpu_timer_pending =
        (timer_flag_reg[`ETT_FLAG_OVF] && timer_control_reg[`ETT_CTL_OVERFLOW_IRQ_MASK]) ||
        (timer_flag_reg[`ETT_FLAG_CH0] && channel_control0_reg[`ETT_CCTL_IM]) ||
        (timer_flag_reg[`ETT_FLAG_CH1] && channel_control1_reg[`ETT_CCTL_IM]);
    assign timer_irq_req = cpu_timer_pending && timer_irq_enable_reg;
    assign timer_irq_vector = IRQ_VECTOR[3:0];

    // write channel: address and data accepted in either order, one write at a time
    assign s_axi_awready = !aw_held_reg;
    assign s_axi_wready = !w_held_reg;
    wire wmapped = (widx >= `ETT_IDX_CNT) && (widx <= `ETT_IDX_IEN);
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= {ADDR_W{1'b0}};
            wdata_reg <= 32'h00000000;
            wstrb0_reg <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ETT_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && !aw_held_reg)
            begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held_reg)
            begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb0_reg <= s_axi_wstrb[0];
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wmapped ? `ETT_RESP_OKAY : `ETT_RESP_DECERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
            end
        end
    end

    // read channel; unmapped addresses read zero with a decode error
    assign s_axi_arready = !s_axi_rvalid;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `ETT_RESP_OKAY;
        end
        else if (s_axi_arvalid && !s_axi_rvalid)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `ETT_RESP_OKAY;
            if (ridx == `ETT_IDX_CNT)
                s_axi_rdata <= {24'h000000, counter_value_reg};
            else if (ridx == `ETT_IDX_CTL)
                s_axi_rdata <= {24'h000000, timer_control_reg};
            else if (ridx == `ETT_IDX_CCTL0)
                s_axi_rdata <= {24'h000000, channel_control0_reg};
            else if (ridx == `ETT_IDX_CC0)
                s_axi_rdata <= {24'h000000, compare_value_ch0_reg};
            else if (ridx == `ETT_IDX_CCTL1)
                s_axi_rdata <= {24'h000000, channel_control1_reg};
            else if (ridx == `ETT_IDX_CC1)
                s_axi_rdata <= {24'h000000, compare_value_ch1_reg};
            else if (ridx == `ETT_IDX_FLAG)
                s_axi_rdata <= {29'h00000000, timer_flag_reg};
            else if (ridx == `ETT_IDX_IEN)
                s_axi_rdata <= {31'h00000000, timer_irq_enable_reg};
            else
            begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `ETT_RESP_DECERR;
            end
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

endmodule

// file: tb/ett_dma_sink.sv
// dma controller stand-in that measures the spacing of one channel's trigger pulses
`timescale 1ns/10ps
module ett_dma_sink (
    input wire aclk,
    input wire aresetn,
    input wire trig,
    output reg [15:0] period
);
    reg [15:0] gap_reg;
    // a real dma engine only sees pulses, so the spacing is all the bench can judge
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            gap_reg <= 16'h0001;
            period <= 16'h0000;
        end
        else if (trig)
        begin
            period <= gap_reg;
            gap_reg <= 16'h0001;
        end
        else
            gap_reg <= gap_reg + 16'h0001;
    end
endmodule

// file: tb/ett_timer_checker.sv
// port-level assertions for the 8-bit compare timer
`timescale 1ns/10ps
module ett_timer_checker #(
    parameter IRQ_VECTOR = 11
) (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire ch0_pin_out,
    input wire ch0_pin_oe,
    input wire cpu_timer_pending,
    input wire timer_irq_req,
    input wire [3:0] timer_irq_vector,
    input wire timer_a_ch0_dma_trigger
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_vector; timer_irq_vector == IRQ_VECTOR; endproperty
    a_vector: assert property (p_vector) else $error("irq vector differs");
    property p_req; timer_irq_req |-> cpu_timer_pending; endproperty
    a_req: assert property (p_req) else $error("request without pending");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
    property p_wblock; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_wblock: assert property (p_wblock) else $error("write taken while answering");
    property p_wresp; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_wresp: assert property (p_wresp) else $error("write answer late");
    property p_rresp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
    a_rresp: assert property (p_rresp) else $error("read answer late");
    property p_rupper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
    a_rupper: assert property (p_rupper) else $error("upper read bits set");
    property p_pin; $changed(ch0_pin_out) |-> $past(ch0_pin_oe); endproperty
    a_pin: assert property (p_pin) else $error("pin moved while disabled");
    property p_dma; timer_a_ch0_dma_trigger |-> $past(ch0_pin_oe); endproperty
    a_dma: assert property (p_dma) else $error("dma pulse without compare");
    c_irq: cover property (timer_irq_req);
    c_dma: cover property (timer_a_ch0_dma_trigger);
    c_stall: cover property (s_axi_bvalid && !s_axi_bready);
endmodule

bind ett_timer ett_timer_checker #(.IRQ_VECTOR(IRQ_VECTOR)) u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .ch0_pin_out(ch0_pin_out), .ch0_pin_oe(ch0_pin_oe), .cpu_timer_pending(cpu_timer_pending),
    .timer_irq_req(timer_irq_req), .timer_irq_vector(timer_irq_vector),
    .timer_a_ch0_dma_trigger(timer_a_ch0_dma_trigger));

// file: tb/test_eight_bit_timer_compare.sv
// self-checking bench of the 8-bit compare timer over its register bus
`timescale 1ns/10ps
`include "ett_regs.vh"
module test_eight_bit_timer_compare;
    reg aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0, p;
    reg [11:0] awa = 12'h000, ara = 12'h000;
    reg [31:0] wd = 32'h00000000, rdat;
    reg [1:0] resp_seen;
    wire awr, wrdy, bv, arr, rv, pin0, oe0, pin1, oe1, pend, irq, dma0, dma1;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [3:0] vec;
    wire [15:0] per0, per1;
    reg tick = 1'b1;
    int fail_count = 0, n_compared = 0, hi = 0;
    ett_timer dut (.aclk(aclk), .aresetn(aresetn), .timer_tick(tick), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(ara),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rready), .ch0_pin_out(pin0), .ch0_pin_oe(oe0), .ch1_pin_out(pin1), .ch1_pin_oe(oe1),
        .cpu_timer_pending(pend), .timer_irq_req(irq), .timer_irq_vector(vec),
        .timer_a_ch0_dma_trigger(dma0), .timer_a_ch1_dma_trigger(dma1));
    ett_dma_sink u_dma0 (.aclk(aclk), .aresetn(aresetn), .trig(dma0), .period(per0));
    ett_dma_sink u_dma1 (.aclk(aclk), .aresetn(aresetn), .trig(dma1), .period(per1));
    // 20 MHz clock
    initial
    begin
        forever #25 aclk = ~aclk;
    end
    task test_done;
        begin
            $display("compared %0d mismatches %0d", n_compared, fail_count);
            if (fail_count == 0 && n_compared > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] exp, input [31:0] got);
        begin
            n_compared++;
            if (got !== exp)
            begin
                fail_count++;
                $display("[ERR] %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // ready is judged at the falling edge so the rising edge sees settled values
    task wr(input [7:0] idx, input [7:0] d);
        reg a, w;
        begin
            @(posedge aclk);
            awa <= {2'b00, idx, 2'b00};
            wd <= {24'h000000, d};
            awv <= 1'b1;
            wv <= 1'b1;
            a = 1'b1;
            w = 1'b1;
            while (a || w)
            begin
                @(negedge aclk);
                a = a && !awr;
                w = w && !wrdy;
                @(posedge aclk);
                if (!a) awv <= 1'b0;
                if (!w) wv <= 1'b0;
            end
            @(negedge aclk);
            while (bv !== 1'b1) @(negedge aclk);
            resp_seen = bresp;
            @(posedge aclk);
            bready <= 1'b1;
            @(posedge aclk);
            bready <= 1'b0;
        end
    endtask
    // late rready on purpose, so the held answer is exercised
    task rd(input [7:0] idx);
        begin
            @(posedge aclk);
            ara <= {2'b00, idx, 2'b00};
            arv <= 1'b1;
            @(negedge aclk);
            while (arr !== 1'b1) @(negedge aclk);
            @(posedge aclk);
            arv <= 1'b0;
            @(negedge aclk);
            while (rv !== 1'b1) @(negedge aclk);
            rdat = rdata;
            resp_seen = rresp;
            @(posedge aclk);
            rready <= 1'b1;
            @(posedge aclk);
            rready <= 1'b0;
        end
    endtask
    task rdc(input [7:0] idx, input [31:0] exp, input string nm);
        begin
            rd(idx);
            chk(nm, exp, rdat);
        end
    endtask
    // watchdog: the sequence needs under 2500 cycles
    initial
    begin
        #(50 * 6000);
        fail_count++;
        $display("[ERR] watchdog expected finish seen hang");
        test_done;
    end
    initial
    begin
        wt(10);
        aresetn <= 1'b1;
        // reset values, read-only counter, unmapped place
        rdc(`ETT_IDX_CTL, 32'h08, "ctl reset");
        rdc(`ETT_IDX_CCTL0, 32'h40, "cctl0 reset");
        wr(`ETT_IDX_CNT, 8'h55);
        chk("ro write resp", `ETT_RESP_OKAY, resp_seen);
        rdc(`ETT_IDX_CNT, 32'h00, "cnt read only");
        rdc(8'hE0, 32'h00, "unmapped data");
        chk("unmapped resp", `ETT_RESP_DECERR, resp_seen);
        // modulo to 4 with divide by 2: five steps of two cycles
        wr(`ETT_IDX_CC0, 8'h04);
        wr(`ETT_IDX_CC1, 8'h02);
        wr(`ETT_IDX_CCTL0, 8'h54);
        wr(`ETT_IDX_CCTL1, 8'h44);
        wr(`ETT_IDX_CTL, 8'h3A);
        wt(60);
        chk("ch0 period", 32'd10, per0);
        chk("ch1 period", 32'd10, per1);
        chk("ch0 oe", 32'h1, oe0);
        chk("ch1 oe", 32'h1, oe1);
        chk("ch1 pin set", 32'h1, pin1);
        @(negedge aclk);
        p = pin0;
        wt(10);
        @(negedge aclk);
        chk("ch0 toggles", {31'h0, ~p}, pin0);
        rd(`ETT_IDX_CNT);
        chk("cnt within cc0", 32'h1, rdat <= 32'h4);
        rdc(`ETT_IDX_FLAG, 32'h07, "modulo flags");
        chk("pending", 32'h1, pend);
        chk("no request", 32'h0, irq);
        wr(`ETT_IDX_IEN, 8'h01);
        chk("request", 32'h1, irq);
        // masks off: flags still set, nothing pends until a mask returns
        wr(`ETT_IDX_CCTL0, 8'h14);
        wr(`ETT_IDX_CCTL1, 8'h04);
        wr(`ETT_IDX_CTL, 8'h32);
        wr(`ETT_IDX_FLAG, 8'h00);
        wt(30);
        rdc(`ETT_IDX_FLAG, 32'h07, "unmasked flags");
        chk("pending masked", 32'h0, pend);
        wr(`ETT_IDX_CTL, 8'h3A);
        chk("new request", 32'h1, irq);
        // up/down to 4: period of eight, channel 1 hit going up and down
        wr(`ETT_IDX_CTL, 8'h1B);
        wr(`ETT_IDX_FLAG, 8'h00);
        wt(40);
        chk("updown ch1 period", 32'd4, per1);
        chk("updown ch0 period", 32'd8, per0);
        rdc(`ETT_IDX_FLAG, 32'h07, "updown flags");
        // centre-aligned pwm on channel 1: set at 2 going up, cleared at 2 going down
        wr(`ETT_IDX_CCTL1, 8'h5C);
        wt(20);
        repeat (16)
        begin
            @(negedge aclk);
            hi = hi + pin1;
        end
        chk("pwm duty", 32'd8, hi);
        // stop freezes, clear zeroes
        wr(`ETT_IDX_CTL, 8'h08);
        rd(`ETT_IDX_CNT);
        wt(5);
        rdc(`ETT_IDX_CNT, rdat, "frozen");
        wr(`ETT_IDX_CTL, 8'h0C);
        rdc(`ETT_IDX_CNT, 32'h00, "cleared");
        // down from 3: passes 2, lands on 0 and stays
        wr(`ETT_IDX_CC0, 8'h03);
        wr(`ETT_IDX_FLAG, 8'h00);
        wr(`ETT_IDX_CTL, 8'h19);
        wt(20);
        rdc(`ETT_IDX_CNT, 32'h00, "down holds zero");
        rd(`ETT_IDX_FLAG);
        chk("down flags", 32'h5, rdat & 32'h5);
        // free running: channel 1 fires every 256 ticks, overflow at the top
        wr(`ETT_IDX_CTL, 8'h0C);
        wr(`ETT_IDX_FLAG, 8'h00);
        wr(`ETT_IDX_CC1, 8'h10);
        wr(`ETT_IDX_CTL, 8'h18);
        wt(600);
        chk("free period", 32'd256, per1);
        rd(`ETT_IDX_FLAG);
        chk("free overflow", 32'h1, rdat & 32'h1);
        // tick held low: a started counter must still stand still
        tick <= 1'b0;
        rd(`ETT_IDX_CNT);
        wt(5);
        rdc(`ETT_IDX_CNT, rdat, "no tick holds");
        test_done;
    end
endmodule
